// File: rtl/inc_dec_word_unit.sv
// Single-step binary decrement / BCD increment on words of an internal
// data memory, with condition flags, APB registers and one interrupt.
// Assumes an APB master on clk; one scan cycle per write of SCAN.
//
// Functional notes
// [RQ1] Single decrement: word minus one, written back
// [RQ2] Level form: one step per scan while on
// [RQ3] Edge form decrement: step only on rising condition
// [RQ4] Single decrement flags: error off, equals, carry, negative
// [RQ5] Single decrement wrap 0000: carry and negative
// [RQ6] Double decrement: upper next word, 32-bit minus one
// [RQ7] Double decrement flags from both words
// [RQ8] Double decrement wrap zero: carry and negative
// [RQ9] Single BCD increment: decimal carry, equals, carry
// [RQ10] BCD rollover 9999 to 0000: equals and carry
// [RQ11] Single BCD: non-decimal digit raises error
// [RQ12] Edge form BCD increment: rising condition only
// [RQ13] Double BCD: non-decimal digit in either raises error
// [RQ14] Double BCD carry: any digit nine to zero
// [RQ15] Double BCD equals when eight digits zero
// [RQ16] Double BCD: upper next word, eight digits
// [RQ17] No step: words and flags unchanged
//
// Added by the designer: the APB register port and the register offsets.
`include "inc_dec_map.svh"
`timescale 1ns/1ps
`default_nettype none

module inc_dec_word_unit #(
    parameter int MEM_AW = 15
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // APB slave
    input  wire inc_dec_pkg::apb_req_s apb_req,
    output var  inc_dec_pkg::apb_rsp_s apb_rsp,
    // Condition flags and interrupt
    output var  inc_dec_pkg::flags_s   flags,
    output logic                       irq
);
    import inc_dec_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0]        ctrl;
        logic              cond_prev;
        logic [MEM_AW-1:0] opnd_addr;
        logic [MEM_AW-1:0] mem_addr;
        flags_s            flg;
        logic [1:0]        status;
        logic [1:0]        mask;
        apb_rsp_s          rsp;
        logic              irq;
    } state_s;

    state_s st_q;
    state_s st_d;

    logic [15:0] mem [2**MEM_AW];

    logic              we_lo;
    logic              we_hi;
    logic [MEM_AW-1:0] wa_lo;
    logic [MEM_AW-1:0] wa_hi;
    logic [15:0]       wdat_lo;
    logic [15:0]       wdat_hi;

    // ==========================================================
    // Digit helpers and register decode
    function automatic logic any_dig(input logic [31:0] o,
                                     input logic [31:0] n,
                                     input logic [3:0]  from,
                                     input logic [3:0]  to,
                                     input int          nd);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < nd && o[4*i+:4] == from && n[4*i+:4] == to) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction : any_dig

    function automatic logic bcd_ok(input logic [31:0] v,
                                    input int          nd);
        logic r;
        r = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i < nd && v[4*i+:4] > 4'h9) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction : bcd_ok

    function automatic logic [31:0] bcd_inc(input logic [31:0] v,
                                            input int          nd);
        logic [31:0] r;
        logic        c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i < nd && c) begin
                if (v[4*i+:4] == 4'h9) begin
                    r[4*i+:4] = 4'h0;
                end else begin
                    r[4*i+:4] = v[4*i+:4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        if (nd < 8) begin
            r[31:16] = 16'h0000;
        end
        return r;
    endfunction : bcd_inc

    function automatic logic reg_mapped(input logic [7:0] a);
        return a == `IDU_CTRL_OFS  || a == `IDU_OPND_OFS  ||
               a == `IDU_SCAN_OFS  || a == `IDU_FLAGS_OFS ||
               a == `IDU_MADDR_OFS || a == `IDU_MDATA_OFS ||
               a == `IDU_STAT_OFS  || a == `IDU_MASK_OFS;
    endfunction : reg_mapped

    // ==========================================================
    // Next state
    always_comb begin
        logic        setup;
        logic        acc;
        logic        wr;
        logic        cond;
        logic        fire;
        logic        dbl;
        logic [31:0] opv;
        logic [31:0] res;
        logic [31:0] rd;
        logic [1:0]  ev;
        int          nd;
        op_e         op;

        st_d  = st_q;
        we_lo = 1'b0;
        we_hi = 1'b0;
        wa_lo = st_q.opnd_addr;
        wa_hi = st_q.opnd_addr + MEM_AW'(1);
        wdat_lo = 16'h0000;
        wdat_hi = 16'h0000;
        res   = 32'h0000_0000;
        ev    = 2'h0;
        rd    = 32'h0000_0000;
        cond  = 1'b0;
        fire  = 1'b0;

        setup = apb_req.psel & ~apb_req.penable;
        acc   = apb_req.psel & apb_req.penable & st_q.rsp.pready;
        wr    = acc & apb_req.pwrite & reg_mapped(apb_req.paddr);

        op  = op_e'(st_q.ctrl[`IDU_CTRL_OP_LSB+:2]);
        dbl = (op == OP_DEC_BIN_DBL) || (op == double_bcd_increment_op);
        nd  = dbl ? 8 : 4;
        opv = {dbl ? mem[wa_hi] : 16'h0000, mem[wa_lo]};

        // Read data captured in the setup phase
        unique case (apb_req.paddr)
            `IDU_CTRL_OFS:  rd = {29'h0, st_q.ctrl};
            `IDU_OPND_OFS:  rd = {{(32-MEM_AW){1'b0}}, st_q.opnd_addr};
            `IDU_SCAN_OFS:  rd = {31'h0, st_q.cond_prev};
            `IDU_FLAGS_OFS: rd = {28'h0, st_q.flg};
            `IDU_MADDR_OFS: rd = {{(32-MEM_AW){1'b0}}, st_q.mem_addr};
            `IDU_MDATA_OFS: rd = {16'h0000, mem[st_q.mem_addr]};
            `IDU_STAT_OFS:  rd = {30'h0, st_q.status};
            `IDU_MASK_OFS:  rd = {30'h0, st_q.mask};
            default:        rd = 32'h0000_0000;
        endcase
        st_d.rsp.pready  = setup;
        st_d.rsp.pslverr = setup & ~reg_mapped(apb_req.paddr);
        if (setup) begin
            st_d.rsp.prdata = rd;
        end

        // Register writes
        if (wr) begin
            unique case (apb_req.paddr)
                `IDU_CTRL_OFS:  st_d.ctrl = apb_req.pwdata[2:0];
                `IDU_OPND_OFS:  st_d.opnd_addr = apb_req.pwdata[MEM_AW-1:0];
                `IDU_MADDR_OFS: st_d.mem_addr = apb_req.pwdata[MEM_AW-1:0];
                `IDU_MASK_OFS:  st_d.mask = apb_req.pwdata[1:0];
                `IDU_MDATA_OFS: begin
                    we_lo = 1'b1;
                    wa_lo = st_q.mem_addr;
                    wdat_lo = apb_req.pwdata[15:0];
                end
                `IDU_SCAN_OFS: begin
                    cond = apb_req.pwdata[`IDU_SCAN_COND_BIT];
                    st_d.cond_prev = cond;
                    // Level form every scan; edge form on rise only
                    fire = cond & (~st_q.ctrl[`IDU_CTRL_EDGE_BIT] | // RQ2
                                   ~st_q.cond_prev);                // RQ3 RQ12
                end
                default: begin
                end
            endcase
        end

        // One step of the selected operation
        if (fire) begin
            ev[`IDU_EV_DONE_BIT] = 1'b1;
            if (op == OP_DEC_BIN || op == OP_DEC_BIN_DBL) begin
                res = dbl ? opv - 32'h1                        // RQ6
                          : {16'h0000, opv[15:0] - 16'h1};     // RQ1
                we_lo = 1'b1;
                we_hi = dbl;
                wdat_lo = res[15:0];
                wdat_hi = res[31:16];
                st_d.flg.error_flag = 1'b0;                    // RQ4 RQ7
                st_d.flg.eq_flag    = (res == 32'h0);          // RQ4 RQ7
                // Wrap from zero sets both carry and negative
                st_d.flg.carry_flag = any_dig(opv, res, 4'h0, 4'hF, nd); // RQ5 RQ8
                st_d.flg.neg_flag   = dbl ? res[31] : res[15]; // RQ5 RQ8
            end else if (!bcd_ok(opv, nd)) begin
                // Bad digit: report, leave the words alone
                st_d.flg.error_flag = 1'b1;                    // RQ11 RQ13
                ev[`IDU_EV_ERR_BIT] = 1'b1;
            end else begin
                res = bcd_inc(opv, nd);                        // RQ9 RQ16
                we_lo = 1'b1;
                we_hi = dbl;
                wdat_lo = res[15:0];
                wdat_hi = res[31:16];
                st_d.flg.error_flag = 1'b0;                    // RQ11 RQ13
                st_d.flg.eq_flag    = (res == 32'h0);          // RQ10 RQ15
                st_d.flg.carry_flag = any_dig(opv, res, 4'h9, 4'h0, nd); // RQ10 RQ14
            end
        end
        // Without fire the words and flags hold                 RQ17

        // Sticky events, cleared by read; a new event wins
        if (acc && !apb_req.pwrite && apb_req.paddr == `IDU_STAT_OFS) begin
            st_d.status = st_q.status & ~st_q.rsp.prdata[1:0];
        end
        st_d.status = st_d.status | ev;
        st_d.irq    = |(st_d.status & st_d.mask);
    end

    // ==========================================================
    // Registers and memory
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q      <= '0;
            st_q.ctrl <= `IDU_CTRL_RST;
            st_q.mask <= `IDU_MASK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk) begin
        if (we_lo) begin
            mem[wa_lo] <= wdat_lo;
        end
        if (we_hi) begin
            mem[wa_hi] <= wdat_hi;
        end
    end

    assign apb_rsp = st_q.rsp;
    assign flags   = st_q.flg;
    assign irq     = st_q.irq;

endmodule : inc_dec_word_unit

`default_nettype wire

// File: rtl/inc_dec_map.svh
// Register offsets, field positions and reset values of the inc/dec unit.
// Assumes byte addressing on a 32-bit APB bus, one word per register.
`ifndef INC_DEC_MAP_SVH
`define INC_DEC_MAP_SVH

`define IDU_ADDR_W        8
`define IDU_CTRL_OFS      8'h00
`define IDU_OPND_OFS      8'h04
`define IDU_SCAN_OFS      8'h08
`define IDU_FLAGS_OFS     8'h0C
`define IDU_MADDR_OFS     8'h10
`define IDU_MDATA_OFS     8'h14
`define IDU_STAT_OFS      8'h18
`define IDU_MASK_OFS      8'h1C

`define IDU_CTRL_OP_LSB   0
`define IDU_CTRL_EDGE_BIT 2
`define IDU_SCAN_COND_BIT 0

`define IDU_FLG_ERR_BIT   0
`define IDU_FLG_EQ_BIT    1
`define IDU_FLG_CARRY_BIT 2
`define IDU_FLG_NEG_BIT   3

`define IDU_EV_DONE_BIT   0
`define IDU_EV_ERR_BIT    1

`define IDU_CTRL_RST      3'h0
`define IDU_MASK_RST      2'h0

`endif

// File: rtl/inc_dec_pkg.sv
// Types shared by the inc/dec unit: operation codes, flags, APB request and response.
// Assumes nothing beyond a SystemVerilog compiler.
package inc_dec_pkg;

    typedef enum logic [1:0] {
        OP_DEC_BIN,
        OP_DEC_BIN_DBL,
        OP_INC_BCD,
        double_bcd_increment_op
    } op_e;

    typedef struct packed {
        logic neg_flag;
        logic carry_flag;
        logic eq_flag;
        logic error_flag;
    } flags_s;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

endpackage : inc_dec_pkg

// File: tb/inc_dec_word_unit_properties.sv
// Port checks of the inc/dec unit, bound to its top module.
// Assumes clk and a synchronous active-high rst.
`include "inc_dec_map.svh"
`timescale 1ns/1ps
`default_nettype none
module idu_checker (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // Watched ports
    input wire inc_dec_pkg::apb_req_s apb_req,
    input wire inc_dec_pkg::apb_rsp_s apb_rsp,
    input wire inc_dec_pkg::flags_s   flags,
    input wire logic                  irq
);
    import inc_dec_pkg::*;
    wire logic scan_end = apb_req.psel && apb_req.penable && apb_rsp.pready
        && apb_req.pwrite && apb_req.paddr == `IDU_SCAN_OFS;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Bus, flag and interrupt relations
    sequence s_setup; apb_req.psel && !apb_req.penable; endsequence
    sequence s_flags_rd;
        s_setup ##0 (!apb_req.pwrite && apb_req.paddr == `IDU_FLAGS_OFS)
        ##1 apb_rsp.pready;
    endsequence
    property p_rdy_next; s_setup |=> apb_rsp.pready; endproperty
    a_rdy_next: assert property (p_rdy_next) else $error("pready late");
    property p_rdy_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready long");
    property p_rdy_acc; apb_rsp.pready |-> apb_req.penable; endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("pready idle");
    property p_unmap;
        s_setup ##0 (apb_req.paddr > `IDU_MASK_OFS) |=> apb_rsp.pslverr;
    endproperty
    a_unmap: assert property (p_unmap) else $error("no pslverr");
    property p_err_zero;
        apb_rsp.pslverr && !apb_req.pwrite |-> apb_rsp.prdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused data");
    property p_flags_hold; !scan_end |=> $stable(flags); endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved");
    property p_flags_rd; s_flags_rd |-> apb_rsp.prdata[3:0] == flags; endproperty
    a_flags_rd: assert property (p_flags_rd) else $error("flags read");
    property p_irq_rst; $fell(rst) |-> !irq; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
endmodule : idu_checker
bind inc_dec_word_unit idu_checker u_chk (.clk(clk), .rst(rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .flags(flags), .irq(irq));
`default_nettype wire

// File: tb/apb_host_model.sv
// APB master standing in for the instruction sequencer.
// Assumes an APB slave on clk; waits for pready, however late.
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
    // Bus
    input  wire logic                  clk,
    output var  inc_dec_pkg::apb_req_s req,
    input  wire inc_dec_pkg::apb_rsp_s rsp
);
    import inc_dec_pkg::*;
    initial req = '0;
    // Called just after a rising edge; idles one cycle after
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wdat, output logic [31:0] rd,
                        output logic err);
        req <= '{1'b1, 1'b0, w, a, wdat};
        @(posedge clk);
        req.penable <= 1'b1;
        // Only the bench watchdog ends a wait
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// File: tb/tb.sv
// Bench for the inc/dec unit: every operation driven over APB.
// Assumes the host model, the bound checker and MEM_AW of 4.
`include "inc_dec_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    import inc_dec_pkg::*;
    logic        clk;
    logic        rst;
    apb_req_s    req;
    apb_rsp_s    rsp;
    flags_s      flags;
    logic        irq;
    logic [31:0] d;
    logic        e;
    int          error_cnt = 0;
    int          checks = 0;
    inc_dec_word_unit #(.MEM_AW(4)) dut (.clk(clk), .rst(rst),
        .apb_req(req), .apb_rsp(rsp), .flags(flags), .irq(irq));
    apb_host_model host (.clk(clk), .req(req), .rsp(rsp));
    // ==========================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] s, x);
        checks++;
        if (s !== x) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        host.xfer(1'b1, a, v, d, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        host.xfer(1'b0, a, 32'h0, d, e);
        chk($sformatf("reg %h", a), d, x);
    endtask : rd
    task automatic irq_is(input logic x);
        @(negedge clk);
        chk("irq", {31'h0, irq}, {31'h0, x});
        @(posedge clk);
    endtask : irq_is
    // Load {upper,lower} at words 5,4, scan n times, check all
    task automatic run(input logic [2:0] c, input int n, input logic cnd,
                       input logic [31:0] w, ew, input logic [3:0] ef);
        wr(`IDU_CTRL_OFS, {29'h0, c});
        wr(`IDU_OPND_OFS, 32'h4);
        wr(`IDU_MADDR_OFS, 32'h5);
        wr(`IDU_MDATA_OFS, {16'h0, w[31:16]});
        wr(`IDU_MADDR_OFS, 32'h4);
        wr(`IDU_MDATA_OFS, {16'h0, w[15:0]});
        repeat (n) wr(`IDU_SCAN_OFS, {31'h0, cnd});
        rd(`IDU_FLAGS_OFS, {28'h0, ef});
        chk("flags", {28'h0, flags}, {28'h0, ef});
        rd(`IDU_MDATA_OFS, {16'h0, ew[15:0]});
        wr(`IDU_MADDR_OFS, 32'h5);
        rd(`IDU_MDATA_OFS, {16'h0, ew[31:16]});
        $display("test done, ctrl %h", c);
    endtask : run
    task automatic conclude();
        $display("compares %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    // ==========================================
    // Clock, watchdog, tests
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`IDU_CTRL_OFS, 32'h0);
        rd(`IDU_MASK_OFS, 32'h0);
        run(3'h0, 1, 1'b1, 32'h0000_0001, 32'h0000_0000, 4'h2);
        run(3'h0, 1, 1'b1, 32'h0000_0000, 32'h0000_FFFF, 4'hC);
        run(3'h0, 3, 1'b1, 32'h0000_0005, 32'h0000_0002, 4'h0);
        run(3'h1, 1, 1'b1, 32'h0000_0000, 32'hFFFF_FFFF, 4'hC);
        run(3'h1, 1, 1'b1, 32'h0001_0000, 32'h0000_FFFF, 4'h4);
        run(3'h2, 1, 1'b1, 32'h0000_9999, 32'h0000_0000, 4'h6);
        run(3'h2, 1, 1'b1, 32'h0000_12A4, 32'h0000_12A4, 4'h7);
        run(3'h3, 1, 1'b1, 32'h0000_9999, 32'h0001_0000, 4'h4);
        run(3'h3, 1, 1'b1, 32'h9999_9999, 32'h0000_0000, 4'h6);
        run(3'h3, 1, 1'b1, 32'h1F00_0000, 32'h1F00_0000, 4'h7);
        run(3'h0, 1, 1'b0, 32'h0000_0005, 32'h0000_0005, 4'h7);
        run(3'h4, 3, 1'b1, 32'h0000_0005, 32'h0000_0004, 4'h0);
        run(3'h6, 1, 1'b0, 32'h0000_0009, 32'h0000_0009, 4'h0);
        run(3'h6, 3, 1'b1, 32'h0000_0009, 32'h0000_0010, 4'h4);
        irq_is(1'b0);
        wr(`IDU_MASK_OFS, 32'h2);
        irq_is(1'b1);
        rd(`IDU_STAT_OFS, 32'h3);
        irq_is(1'b0);
        run(3'h2, 1, 1'b1, 32'h0000_12A4, 32'h0000_12A4, 4'h5);
        irq_is(1'b1);
        wr(`IDU_FLAGS_OFS, 32'hF);
        rd(`IDU_FLAGS_OFS, 32'h5);
        host.xfer(1'b0, 8'h20, 32'h0, d, e);
        chk("pslverr", {31'h0, e}, 32'h1);
        chk("unmapped", d, 32'h0);
        conclude();
    end
endmodule : tb
`default_nettype wire
